/* hdl/qs_status_pkg.sv */
package qs_status_pkg;

    // ****************************************************************
    // Widths and reset values.
    // ****************************************************************
    localparam int unsigned STATUS_WIDTH = 16;
    localparam logic [STATUS_WIDTH-1:0] ZERO_WORD = 16'h0000;

    // ****************************************************************
    // Register selection for a query.
    // ****************************************************************
    typedef enum logic {
        SEL_CONDITION = 1'b0,
        SEL_EVENT = 1'b1
    } reg_sel_t;

    // ****************************************************************
    // Query request and answer carriers.
    // ****************************************************************
    typedef struct packed {
        logic rd_stb;
        logic wr_stb;
        reg_sel_t sel;
        logic [STATUS_WIDTH-1:0] wr_data;
    } query_req_t;

    typedef struct packed {
        logic valid;
        logic [STATUS_WIDTH-1:0] data;
    } query_rsp_t;

    localparam query_rsp_t RSP_RESET = '{valid: 1'b0, data: ZERO_WORD};

endpackage

/* hdl/qs_transition_filter.sv */
`timescale 1ns/1ps

module qs_transition_filter (
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] cond_now_i,  // Condition this cycle
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] cond_prev_i, // Condition one cycle earlier
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] rising_i,    // Rising transition filter
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] falling_i,   // Falling transition filter
    output logic [qs_status_pkg::STATUS_WIDTH-1:0] set_o            // Event set request per bit
);

    // ****************************************************************
    // Per-bit polarity filter between condition and event.
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < qs_status_pkg::STATUS_WIDTH; gi++) begin : g_bit
            wire rose;
            wire fell;
            assign rose = cond_now_i[gi] & ~cond_prev_i[gi] & rising_i[gi];
            assign fell = ~cond_now_i[gi] & cond_prev_i[gi] & falling_i[gi];
            assign set_o[gi] = rose | fell;
        end
    endgenerate

endmodule

/* hdl/questionable_status_regs.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Event bits latch filtered edges and stay set until a clearing read.
// - Host writes never change the event register.
// - Reading the event register clears all of its bits except those set by a filtered edge in the same cycle.
// - The instrument reset command leaves the event register untouched.
// - Condition register mirrors the live, unlatched status inputs every cycle.
// - Reading the condition register does not change it.
// - A condition bit falls to zero once its condition is gone.
// - Instrument reset clears condition bits except those still active.
// - Reads return the plain binary-weighted bit pattern, bit n worth two to n.
// - A zero-to-one condition change sets the event bit when rising filter is one.
// - A one-to-zero condition change sets the event bit when falling filter is one.
// - Summary bit is high when any event bit is set and enabled.
module questionable_status_regs (
    input wire logic sys_clk_i,                                           // System clock, 20 MHz
    input wire logic rst_b_i,                                             // Asynchronous reset, active low
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] status_i,          // Live status pins, asynchronous
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] rising_filter_i,   // Rising transition filter
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] falling_filter_i,  // Falling transition filter
    input wire logic [qs_status_pkg::STATUS_WIDTH-1:0] enable_mask_i,     // Summary enable mask
    input wire logic inst_reset_i,                                        // Instrument reset command pulse
    input wire qs_status_pkg::query_req_t query_i,                        // Register query request
    output qs_status_pkg::query_rsp_t query_o,                            // Register query answer
    output logic questionable_summary_bit_o                               // Questionable summary bit
);

    // ****************************************************************
    // Status input synchroniser and condition register.
    // ****************************************************************
    logic [qs_status_pkg::STATUS_WIDTH-1:0] status_meta;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] status_sync;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] cond;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] cond_prev;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] next_cond;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_meta <= qs_status_pkg::ZERO_WORD;
            status_sync <= qs_status_pkg::ZERO_WORD;
        end else begin
            status_meta <= status_i;
            status_sync <= status_meta;
        end
    end

    // An instrument reset clears every bit, then bits whose condition still holds return at once.
    assign next_cond = inst_reset_i ? (qs_status_pkg::ZERO_WORD | status_sync) : status_sync;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cond <= qs_status_pkg::ZERO_WORD;
            cond_prev <= qs_status_pkg::ZERO_WORD;
        end else begin
            cond <= next_cond;
            cond_prev <= cond;
        end
    end

    // ****************************************************************
    // Query decode.
    // ****************************************************************
    wire rd_cond;
    wire rd_event;
    wire wr_any;
    assign rd_cond = query_i.rd_stb && (query_i.sel == qs_status_pkg::SEL_CONDITION);
    assign rd_event = query_i.rd_stb && (query_i.sel == qs_status_pkg::SEL_EVENT);
    assign wr_any = query_i.wr_stb;

    // ****************************************************************
    // Event register.
    // ****************************************************************
    logic [qs_status_pkg::STATUS_WIDTH-1:0] event_latch;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] next_event;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] set_vec;
    logic [qs_status_pkg::STATUS_WIDTH-1:0] kept_event;

    qs_transition_filter u_filter (
        .cond_now_i(cond),
        .cond_prev_i(cond_prev),
        .rising_i(rising_filter_i),
        .falling_i(falling_filter_i),
        .set_o(set_vec)
    );

    // Writes and the instrument reset do not enter this path; only a read clears.
    assign kept_event = rd_event ? qs_status_pkg::ZERO_WORD : event_latch;
    assign next_event = kept_event | set_vec;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            event_latch <= qs_status_pkg::ZERO_WORD;
        end else begin
            event_latch <= next_event;
        end
    end

    // ****************************************************************
    // Query answer and summary bit.
    // ****************************************************************
    wire [qs_status_pkg::STATUS_WIDTH-1:0] rd_value;
    wire summary_any;
    assign rd_value = rd_event ? event_latch : cond;
    assign summary_any = |(event_latch & enable_mask_i);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            query_o <= qs_status_pkg::RSP_RESET;
            questionable_summary_bit_o <= 1'b0;
        end else begin
            query_o.valid <= query_i.rd_stb;
            query_o.data <= query_i.rd_stb ? rd_value : qs_status_pkg::ZERO_WORD;
            questionable_summary_bit_o <= summary_any;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    AST_EVENT_HOLD: assert property (
        !rd_event |=> ((event_latch & $past(event_latch)) == $past(event_latch))
    ) else $error("Event bit lost without a read.");

    AST_WRITE_IGNORED: assert property (
        (wr_any && !rd_event && (set_vec == qs_status_pkg::ZERO_WORD)) |=> $stable(event_latch)
    ) else $error("Host write changed the event register.");

    AST_READ_CLEARS: assert property (
        (rd_event && (set_vec == qs_status_pkg::ZERO_WORD)) |=> (event_latch == qs_status_pkg::ZERO_WORD)
    ) else $error("Event read did not clear the register.");

    AST_RESET_KEEPS_EVENT: assert property (
        (inst_reset_i && !rd_event && (set_vec == qs_status_pkg::ZERO_WORD)) |=> $stable(event_latch)
    ) else $error("Instrument reset changed the event register.");

    AST_COND_LIVE: assert property (
        ##1 (cond == $past(status_sync))
    ) else $error("Condition register does not follow the status.");

    AST_COND_READ_NO_CLEAR: assert property (
        (rd_cond && (status_sync == cond)) |=> $stable(cond)
    ) else $error("Condition read altered the condition register.");

    AST_COND_DROPS: assert property (
        ##1 ((cond & ~$past(status_sync)) == qs_status_pkg::ZERO_WORD)
    ) else $error("Condition bit stayed set after its condition went away.");

    AST_RESET_COND: assert property (
        inst_reset_i |=> (cond == $past(status_sync))
    ) else $error("Instrument reset mishandled the condition register.");

    AST_READ_VALUE: assert property (
        rd_event |=> (query_o.valid && (query_o.data == $past(event_latch)))
    ) else $error("Event read returned a wrong value.");

    AST_COND_READ_VALUE: assert property (
        rd_cond |=> (query_o.valid && (query_o.data == $past(cond)))
    ) else $error("Condition read returned a wrong value.");

    AST_RISE_SETS: assert property (
        ((cond & ~cond_prev & rising_filter_i) != qs_status_pkg::ZERO_WORD) |=> (event_latch != qs_status_pkg::ZERO_WORD)
    ) else $error("Rising edge did not set an event bit.");

    AST_FALL_SETS: assert property (
        ((~cond & cond_prev & falling_filter_i) != qs_status_pkg::ZERO_WORD) |=> (event_latch != qs_status_pkg::ZERO_WORD)
    ) else $error("Falling edge did not set an event bit.");

    AST_SUMMARY: assert property (
        ##1 (questionable_summary_bit_o == $past(summary_any))
    ) else $error("Summary bit disagrees with enabled event bits.");

    AST_SET_BEATS_READ: assert property (
        (rd_event && (set_vec != qs_status_pkg::ZERO_WORD)) |=> (event_latch == $past(set_vec))
    ) else $error("Edge lost in the cycle of a clearing read.");

    AST_IDLE_ANSWER: assert property (
        !query_i.rd_stb |=> (query_o == qs_status_pkg::RSP_RESET)
    ) else $error("Answer present without a read.");

    AST_SUMMARY_LOW: assert property (
        ((event_latch & enable_mask_i) == qs_status_pkg::ZERO_WORD) |=> !questionable_summary_bit_o
    ) else $error("Summary bit high with no enabled event bit.");

    // ****************************************************************
    // Per-bit checks.
    // ****************************************************************
    genvar bi;
    generate
        for (bi = 0; bi < qs_status_pkg::STATUS_WIDTH; bi++) begin : g_bit_chk
            AST_BIT_RISE: assert property (
                (cond[bi] && !cond_prev[bi] && rising_filter_i[bi]) |=> event_latch[bi]
            ) else $error("Rising edge of a condition bit did not set its event bit.");

            AST_BIT_FALL: assert property (
                (!cond[bi] && cond_prev[bi] && falling_filter_i[bi]) |=> event_latch[bi]
            ) else $error("Falling edge of a condition bit did not set its event bit.");

            AST_BIT_QUIET: assert property (
                !(rising_filter_i[bi] || falling_filter_i[bi]) |-> !set_vec[bi]
            ) else $error("Event set request with both filters off.");

            AST_BIT_HELD: assert property (
                (event_latch[bi] && !rd_event) |=> event_latch[bi]
            ) else $error("Event bit fell without a clearing read.");

            AST_BIT_NO_SPURIOUS: assert property (
                (!event_latch[bi] && !set_vec[bi]) |=> !event_latch[bi]
            ) else $error("Event bit rose without a filtered edge.");

            AST_BIT_CLEAR: assert property (
                (rd_event && !set_vec[bi]) |=> !event_latch[bi]
            ) else $error("Event bit survived a clearing read.");

            AST_BIT_SURVIVES: assert property (
                (rd_event && set_vec[bi]) |=> event_latch[bi]
            ) else $error("Event bit lost when its edge met a clearing read.");
        end
    endgenerate

endmodule

/* verif/questionable_status_regs_tb.sv */
`timescale 1ns/1ps

module questionable_status_regs_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] status = 16'h0000;
    logic [15:0] rise_f = 16'hFFFF;
    logic [15:0] fall_f = 16'h0000;
    logic [15:0] mask = 16'h0004;
    logic inst_reset = 1'b0;
    qs_status_pkg::query_req_t req = '0;
    qs_status_pkg::query_rsp_t rsp;
    logic summary;
    logic [15:0] acc = 16'h0000;
    int err_count = 0;
    int cmp_count = 0;
    questionable_status_regs dut_u (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .status_i(status), .inst_reset_i(inst_reset),
        .rising_filter_i(rise_f), .falling_filter_i(fall_f), .enable_mask_i(mask),
        .query_i(req), .query_o(rsp), .questionable_summary_bit_o(summary)
    );
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input qs_status_pkg::reg_sel_t sel, input logic [15:0] exp, input string name);
        @(negedge sys_clk);
        req.rd_stb = 1'b1;
        req.sel = sel;
        @(negedge sys_clk);
        req.rd_stb = 1'b0;
        chk(name, {rsp.valid, rsp.data}, {1'b1, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(3000 * 50);
        err_count++;
        conclude();
    end
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        rd(qs_status_pkg::SEL_CONDITION, 16'h0000, "cond after reset");
        rd(qs_status_pkg::SEL_EVENT, 16'h0000, "event after reset");
        $display("test reset done");
        status = 16'h0014;
        idle(8);
        rd(qs_status_pkg::SEL_CONDITION, 16'h0014, "cond weighted");
        rd(qs_status_pkg::SEL_CONDITION, 16'h0014, "cond reread");
        chk("summary enabled", {16'h0000, summary}, 17'h00001);
        mask = 16'h0001;
        idle(2);
        chk("summary masked", {16'h0000, summary}, 17'h00000);
        mask = 16'h0004;
        req.wr_stb = 1'b1;
        req.wr_data = 16'hFFFF;
        idle(1);
        req.wr_stb = 1'b0;
        rd(qs_status_pkg::SEL_EVENT, 16'h0014, "event rising");
        rd(qs_status_pkg::SEL_EVENT, 16'h0000, "event cleared");
        idle(1);
        chk("summary after clear", {16'h0000, summary}, 17'h00000);
        req.wr_stb = 1'b1;
        idle(1);
        req.wr_stb = 1'b0;
        rd(qs_status_pkg::SEL_EVENT, 16'h0000, "event after write");
        $display("test rising done");
        rise_f = 16'h0000;
        fall_f = 16'hFFFF;
        status = 16'h0000;
        idle(8);
        rd(qs_status_pkg::SEL_CONDITION, 16'h0000, "cond dropped");
        rd(qs_status_pkg::SEL_EVENT, 16'h0014, "event falling");
        $display("test falling done");
        rise_f = 16'hFFFF;
        fall_f = 16'h0000;
        status = 16'h0001;
        idle(8);
        inst_reset = 1'b1;
        idle(1);
        inst_reset = 1'b0;
        req.rd_stb = 1'b1;
        req.sel = qs_status_pkg::SEL_CONDITION;
        idle(1);
        req.rd_stb = 1'b0;
        chk("active cond kept", {rsp.valid, rsp.data}, 17'h10001);
        rd(qs_status_pkg::SEL_EVENT, 16'h0001, "event kept by reset");
        $display("test instrument reset done");
        status = 16'h8000;
        idle(1);
        req.rd_stb = 1'b1;
        repeat (10) begin
            @(negedge sys_clk);
            acc = acc | (rsp.valid ? rsp.data : 16'h0000);
        end
        req.rd_stb = 1'b0;
        idle(1);
        chk("answer when idle", {rsp.valid, rsp.data}, 17'h00000);
        chk("edge during reads", {1'b1, acc}, {1'b1, 16'h8000});
        rd(qs_status_pkg::SEL_EVENT, 16'h0000, "event after burst");
        $display("test read collision done");
        conclude();
    end
endmodule
